// ==== hw/access_channel_arbiter.sv ====
`timescale 1ns/1ps
// Operation
// R1: at most one channel holds exclusive control at any time
// R2: lock value 0 allows other channels; 1 blocks inputs and commissioning; code blocks new commission grants and unowned local cmds; an owner keeps control
// R3: after power-on no channel holds exclusive access
// R4: halt, fault reset, enable, limits, reference, safe torque off stay effective
// R5: channel lock never suppresses the halt input
// R6: lock register writes take effect immediately
// R7: each tcp connection is its own channel; only one controls
// R8: all unit-255 connections of one client merge into one channel
// R9: unit-255 requests from any other client get an error response
// R10: io scanning channel owns control by default; kept while moving
// R11: commissioning gets exclusive access when its switch is on
// R12: commands from locked-out channels are ignored while lock holds
module access_channel_arbiter
    import access_arb_pkg::*;
#(
    parameter int CONN_W   = access_arb_pkg::CONN_ID_W,
    parameter int CLIENT_W = access_arb_pkg::CLIENT_ID_W
) (
    input  wire logic                 mclk_in,
    input  wire logic                 rst_in,
    // parameter register port
    input  wire logic                 reg_wr_in,
    input  wire logic [15:0]          reg_addr_in,
    input  wire logic [15:0]          reg_wdata_in,
    output logic      [15:0]          reg_rdata_out,
    output logic                      reg_err_out,
    // tcp request
    input  wire logic                 tcp_req_in,
    input  wire logic [CONN_W-1:0]    tcp_conn_in,
    input  wire logic [CLIENT_W-1:0]  tcp_client_in,
    input  wire logic [7:0]           tcp_unit_in,
    input  wire logic                 tcp_ctrl_in,
    input  wire logic                 tcp_close_in,
    output logic                      tcp_ack_out,
    output logic                      tcp_err_out,
    // other channels
    input  wire logic                 comm_excl_in,
    input  wire logic                 comm_ctrl_in,
    input  wire logic                 io_ctrl_in,
    input  wire logic                 web_ctrl_in,
    input  wire logic                 moving_in,
    // always-effective signals
    input  wire logic                 halt_in,
    input  wire logic                 fault_reset_in,
    input  wire logic                 enable_in,
    input  wire logic                 positive_limit_input_in,
    input  wire logic                 negative_limit_input_in,
    input  wire logic                 ref_switch_in,
    input  wire logic [1:0]           safe_torque_off_inputs_in,
    // results
    output access_arb_pkg::ch_kind_t  owner_out,
    output logic      [CONN_W-1:0]    owner_conn_out,
    output logic                      ctrl_cmd_out,
    output logic                      halt_out,
    output logic                      fault_reset_out,
    output logic                      enable_out,
    output logic                      limits_out,
    output logic                      ref_out,
    output logic      [1:0]           safe_torque_off_out
);
    import access_arb_pkg::*;

    initial begin
        if (CONN_W < 1 || CLIENT_W < 1) $error("bad id widths");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]         lock_q, lock_d;
    ch_kind_t            owner_q, owner_d;
    logic [CONN_W-1:0]   oconn_q, oconn_d;
    logic                ack_q, ack_d, err_q, err_d, cmd_q, cmd_d;
    logic                rerr_q, rerr_d;
    logic [15:0]         rdata_q, rdata_d;
    logic [6:0]          safe_q;
    logic                io_owned;
    logic [CLIENT_W-1:0] io_owner;
    logic                is_unit;
    logic                io_claim, io_release, io_foreign;

    assign is_unit    = tcp_req_in && (tcp_unit_in == IO_SCAN_UNIT_ID);
    assign io_foreign = is_unit && io_owned && (io_owner != tcp_client_in); // [R9]
    assign io_claim   = is_unit && !io_owned; // [R8]
    // refused while moving, so a later close can still free the channel
    assign io_release = tcp_close_in && io_owned && (io_owner == tcp_client_in) && !moving_in; // [R10]

    conn_owner_table #(.CLIENT_W(CLIENT_W)) u_owner (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .claim_in   (io_claim),
        .release_in (io_release),
        .client_in  (tcp_client_in),
        .owned_out  (io_owned),
        .owner_out  (io_owner)
    );

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    always_comb begin
        lock_d  = lock_q;
        owner_d = owner_q;
        oconn_d = oconn_q;
        ack_d   = 1'b0;
        err_d   = 1'b0;
        cmd_d   = 1'b0;
        rerr_d  = 1'b0;
        rdata_d = (reg_addr_in == LOCK_REG_OFFSET) ? lock_q : 16'h0000;
        if (reg_wr_in) begin
            if (reg_addr_in == LOCK_REG_OFFSET && reg_wdata_in <= LOCK_VAL_MAX) begin
                lock_d = reg_wdata_in; // [R6]
            end else begin
                rerr_d = 1'b1;
            end
        end
        // commissioning exclusive switch, blocked by fieldbus lock
        if (comm_excl_in && owner_q == CH_NONE && lock_q != LOCK_VAL_LOCK) begin
            owner_d = CH_COMMISSION; // [R11] [R1]
        end else if (!comm_excl_in && owner_q == CH_COMMISSION) begin
            owner_d = CH_NONE;
        end
        if (tcp_req_in) begin
            if (io_foreign) begin
                err_d = 1'b1; // [R9]
            end else begin
                ack_d = 1'b1;
                if (tcp_ctrl_in) begin
                    if (is_unit && (owner_q == CH_NONE || owner_q == CH_IO_SCAN)) begin
                        owner_d = CH_IO_SCAN; // [R10] [R8]
                        cmd_d   = 1'b1;
                    end else if (!is_unit && owner_q == CH_NONE) begin
                        owner_d = CH_FIELDBUS; // [R7]
                        oconn_d = tcp_conn_in;
                        cmd_d   = 1'b1;
                    end else if (!is_unit && owner_q == CH_FIELDBUS && oconn_q == tcp_conn_in) begin
                        cmd_d = 1'b1;
                    end
                end
            end
        end
        if (tcp_close_in && owner_q == CH_FIELDBUS && oconn_q == tcp_conn_in) begin
            owner_d = CH_NONE;
        end
        if (io_release && owner_q == CH_IO_SCAN && !moving_in) begin
            owner_d = CH_NONE; // [R10]
        end
        // local channels only act when nobody else owns control
        if (owner_q == CH_COMMISSION && comm_ctrl_in) begin
            cmd_d = 1'b1;
        end else if (owner_q == CH_NONE && lock_q != LOCK_VAL_LOCK) begin
            if (comm_ctrl_in || io_ctrl_in || web_ctrl_in) begin
                cmd_d = 1'b1; // [R2] [R12]
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_q  <= LOCK_REG_RESET;
            owner_q <= CH_NONE; // [R3]
            oconn_q <= '0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            cmd_q   <= 1'b0;
            rerr_q  <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            lock_q  <= lock_d;
            owner_q <= owner_d;
            oconn_q <= oconn_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
            cmd_q   <= cmd_d;
            rerr_q  <= rerr_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // always-effective signals, never gated by ownership or lock
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            safe_q <= 7'h00;
        end else begin
            safe_q <= {halt_in, fault_reset_in, enable_in, // [R4] [R5]
                       positive_limit_input_in | negative_limit_input_in,
                       ref_switch_in, safe_torque_off_inputs_in};
        end
    end

    assign reg_rdata_out   = rdata_q;
    assign reg_err_out     = rerr_q;
    assign tcp_ack_out     = ack_q;
    assign tcp_err_out     = err_q;
    assign owner_out       = owner_q;
    assign owner_conn_out  = oconn_q;
    assign ctrl_cmd_out    = cmd_q;
    assign halt_out        = safe_q[6];
    assign fault_reset_out = safe_q[5];
    assign enable_out      = safe_q[4];
    assign limits_out      = safe_q[3];
    assign ref_out         = safe_q[2];
    assign safe_torque_off_out = safe_q[1:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_lock_immediate: assert property (@(posedge mclk_in) disable iff (rst_in) // [R6]
        reg_wr_in && reg_addr_in == LOCK_REG_OFFSET && reg_wdata_in <= LOCK_VAL_MAX
        |=> lock_q == $past(reg_wdata_in)) else $error("lock write not applied");
    a_halt_passes: assert property (@(posedge mclk_in) disable iff (rst_in) // [R5]
        !rst_in && halt_in |=> halt_out) else $error("halt blocked");
    a_torque_off_passes: assert property (@(posedge mclk_in) disable iff (rst_in) // [R4]
        !rst_in |=> safe_torque_off_out == $past(safe_torque_off_inputs_in))
        else $error("safe torque off not passed");
    a_foreign_err: assert property (@(posedge mclk_in) disable iff (rst_in) // [R9]
        io_foreign |=> tcp_err_out && !tcp_ack_out) else $error("foreign unit 255 not refused");
    a_comm_locked: assert property (@(posedge mclk_in) disable iff (rst_in) // [R2]
        lock_q == LOCK_VAL_LOCK && owner_q == CH_NONE |=> owner_q != CH_COMMISSION)
        else $error("commissioning took control under lock");
    a_io_kept_moving: assert property (@(posedge mclk_in) disable iff (rst_in) // [R10]
        owner_q == CH_IO_SCAN && moving_in |=> owner_q == CH_IO_SCAN) else $error("io scan revoked while moving");
    a_fb_single: assert property (@(posedge mclk_in) disable iff (rst_in) // [R7]
        owner_q == CH_FIELDBUS && tcp_req_in && tcp_ctrl_in && tcp_conn_in != oconn_q && !is_unit
        |=> !ctrl_cmd_out) else $error("second tcp connection controlled");
    a_lock_ignore: assert property (@(posedge mclk_in) disable iff (rst_in) // [R12]
        owner_q == CH_FIELDBUS && !tcp_req_in |=> !ctrl_cmd_out) else $error("locked-out command passed");
    a_comm_grant: assert property (@(posedge mclk_in) disable iff (rst_in) // [R11]
        !rst_in && comm_excl_in && owner_q == CH_NONE && lock_q != LOCK_VAL_LOCK |=> owner_q == CH_COMMISSION)
        else $error("commissioning not granted");
    c_fb_own: cover property (@(posedge mclk_in) owner_q == CH_FIELDBUS);
    c_io_own: cover property (@(posedge mclk_in) owner_q == CH_IO_SCAN);
    c_comm_own: cover property (@(posedge mclk_in) owner_q == CH_COMMISSION);
    c_err: cover property (@(posedge mclk_in) tcp_err_out);
endmodule

// ==== hw/access_arb_pkg.sv ====
package access_arb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] LOCK_REG_OFFSET = 16'h013C;
    localparam int          LOCK_REG_WIDTH  = 16;
    localparam logic [15:0] LOCK_REG_RESET  = 16'h0000;
    localparam logic [15:0] LOCK_VAL_ALLOW  = 16'h0000;
    localparam logic [15:0] LOCK_VAL_LOCK   = 16'h0001;
    localparam logic [15:0] LOCK_VAL_MAX    = 16'h0001;
    localparam logic [7:0]  IO_SCAN_UNIT_ID = 8'hFF;
    // ------------------------------------------------------------
    // channel classes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CH_NONE,
        CH_FIELDBUS,
        CH_IO_SCAN,
        CH_COMMISSION,
        CH_INPUTS,
        CH_WEB
    } ch_kind_t;
    localparam int CONN_ID_W   = 4;
    localparam int CLIENT_ID_W = 8;
endpackage

// ==== hw/conn_owner_table.sv ====
`timescale 1ns/1ps
// single record of which client owns the io scanning channel
module conn_owner_table #(
    parameter int CLIENT_W = 8
) (
    input  wire logic                mclk_in,
    input  wire logic                rst_in,
    input  wire logic                claim_in,
    input  wire logic                release_in,
    input  wire logic [CLIENT_W-1:0] client_in,
    output logic                     owned_out,
    output logic [CLIENT_W-1:0]      owner_out
);
    logic                owned_q;
    logic                owned_d;
    logic [CLIENT_W-1:0] owner_q;
    logic [CLIENT_W-1:0] owner_d;

    initial begin
        if (CLIENT_W < 1) $error("client width too small");
    end

    always_comb begin
        owned_d = owned_q;
        owner_d = owner_q;
        if (release_in) begin
            owned_d = 1'b0;
        end else if (claim_in && !owned_q) begin
            owned_d = 1'b1;
            owner_d = client_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            owned_q <= 1'b0;
            owner_q <= '0;
        end else begin
            owned_q <= owned_d;
            owner_q <= owner_d;
        end
    end

    assign owned_out = owned_q;
    assign owner_out = owner_q;
endmodule

// ==== tb/access_partner.sv ====
`timescale 1ns/1ps
// --------
// far side: tcp clients, commissioning tool, local pins
// --------
module access_partner
    import access_arb_pkg::*;
(
    input  wire logic                               mclk_in,
    output logic                                    req_out,
    output logic                                    close_out,
    output logic [access_arb_pkg::CONN_ID_W-1:0]    conn_out,
    output logic [access_arb_pkg::CLIENT_ID_W-1:0]  client_out,
    output logic [7:0]                              unit_out,
    output logic                                    ctrl_out,
    output logic [4:0]                              local_out,
    output logic [7:0]                              pins_out
);
    initial begin
        req_out = 1'h0;
        close_out = 1'h0;
        conn_out = '0;
        client_out = '0;
        unit_out = 8'h00;
        ctrl_out = 1'h0;
        local_out = 5'h00;
        pins_out = 8'h00;
    end
    // one request or close; fields inverted once released
    // callers keep unit 255 to one client at a time unless testing refusal
    task automatic send(input logic [CONN_ID_W-1:0] c, input logic [CLIENT_ID_W-1:0] k,
                        input logic [7:0] u, input logic t, input logic cl);
        @(posedge mclk_in);
        req_out <= !cl;
        close_out <= cl;
        conn_out <= c;
        client_out <= k;
        unit_out <= u;
        ctrl_out <= t;
        @(posedge mclk_in);
        req_out <= 1'h0;
        close_out <= 1'h0;
        conn_out <= ~c;
        client_out <= ~k;
        unit_out <= ~u;
        ctrl_out <= ~t;
        #1;
    endtask
    // local levels: excl, comm cmd, io cmd, web cmd, moving
    task automatic drive(input logic [4:0] lv, input logic [7:0] pv);
        @(posedge mclk_in);
        local_out <= lv;
        pins_out <= pv;
    endtask
endmodule

// ==== tb/access_channel_arbiter_test.sv ====
`timescale 1ns/1ps
module access_channel_arbiter_test;
    import access_arb_pkg::*;
    logic                   mclk_in, rst_in, reg_wr_in, reg_err_out;
    logic [15:0]            reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic                   tcp_req_in, tcp_ctrl_in, tcp_close_in, tcp_ack_out, tcp_err_out;
    logic [CONN_ID_W-1:0]   tcp_conn_in, owner_conn_out;
    logic [CLIENT_ID_W-1:0] tcp_client_in;
    logic [7:0]             tcp_unit_in, pins;
    logic [4:0]             lv;
    logic                   ctrl_cmd_out, halt_out, fault_reset_out, enable_out, limits_out, ref_out;
    logic [1:0]             safe_torque_off_out;
    ch_kind_t               owner_out;
    int                     fails, cmp_count;
    logic [7:0]             pv [4] = '{8'hFF, 8'h00, 8'h81, 8'h5A};

    access_channel_arbiter dut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_err_out(reg_err_out), .tcp_req_in(tcp_req_in), .tcp_conn_in(tcp_conn_in),
        .tcp_client_in(tcp_client_in), .tcp_unit_in(tcp_unit_in), .tcp_ctrl_in(tcp_ctrl_in),
        .tcp_close_in(tcp_close_in), .tcp_ack_out(tcp_ack_out), .tcp_err_out(tcp_err_out),
        .comm_excl_in(lv[4]), .comm_ctrl_in(lv[3]), .io_ctrl_in(lv[2]), .web_ctrl_in(lv[1]),
        .moving_in(lv[0]), .halt_in(pins[7]), .fault_reset_in(pins[6]), .enable_in(pins[5]),
        .positive_limit_input_in(pins[4]), .negative_limit_input_in(pins[3]),
        .ref_switch_in(pins[2]), .safe_torque_off_inputs_in(pins[1:0]), .owner_out(owner_out),
        .owner_conn_out(owner_conn_out), .ctrl_cmd_out(ctrl_cmd_out), .halt_out(halt_out),
        .fault_reset_out(fault_reset_out), .enable_out(enable_out), .limits_out(limits_out),
        .ref_out(ref_out), .safe_torque_off_out(safe_torque_off_out));
    access_partner p (.mclk_in(mclk_in), .req_out(tcp_req_in), .close_out(tcp_close_in),
        .conn_out(tcp_conn_in), .client_out(tcp_client_in), .unit_out(tcp_unit_in),
        .ctrl_out(tcp_ctrl_in), .local_out(lv), .pins_out(pins));

    initial begin
        mclk_in = 1'h0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // --------
    // tasks
    // --------
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        @(posedge mclk_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'h0;
        #1;
        chk(16'(reg_err_out), 16'(e), "reg err");
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        @(posedge mclk_in);
        #1;
        chk(reg_rdata_out, e, "rdata");
    endtask
    task automatic tq(input logic [CONN_ID_W-1:0] c, input logic [7:0] k, input logic [7:0] u,
                      input logic t, input logic cl, input logic [1:0] ec, input ch_kind_t eo);
        p.send(c, k, u, t, cl);
        chk(16'({tcp_err_out, ctrl_cmd_out}), 16'(ec), "err/cmd");
        chk(16'(owner_out), 16'(eo), "owner");
    endtask
    task automatic rst;
        @(posedge mclk_in);
        rst_in <= 1'h1;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'h0;
        #1;
        chk(16'(owner_out), 16'(CH_NONE), "reset owner");
        rd(LOCK_REG_OFFSET, LOCK_REG_RESET);
    endtask
    initial begin
        repeat (3000) @(posedge mclk_in);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        results;
    end
    // --------
    // tests
    // --------
    initial begin
        fails = 0;
        cmp_count = 0;
        rst_in = 1'h1;
        reg_wr_in = 1'h0;
        reg_addr_in = 16'h0000;
        reg_wdata_in = 16'h0000;
        rst;
        rd(16'h0140, 16'h0000);
        $display("test reset done");
        wr(LOCK_REG_OFFSET, LOCK_VAL_LOCK, 1'h0);
        rd(LOCK_REG_OFFSET, LOCK_VAL_LOCK);
        wr(LOCK_REG_OFFSET, 16'h0002, 1'h1);
        rd(LOCK_REG_OFFSET, LOCK_VAL_LOCK);
        wr(16'h0140, 16'h0001, 1'h1);
        $display("test register done");
        p.drive(5'h1E, 8'h00);
        repeat (3) begin
            @(posedge mclk_in);
            #1;
            chk(16'({ctrl_cmd_out, owner_out}), 16'({1'h0, CH_NONE}), "locked local");
        end
        wr(LOCK_REG_OFFSET, LOCK_VAL_ALLOW, 1'h0);
        @(posedge mclk_in);
        #1;
        chk(16'(owner_out), 16'(CH_COMMISSION), "commission grant");
        p.drive(5'h10, 8'h00);
        tq(4'h3, 8'h33, 8'h01, 1'h1, 1'h0, 2'h0, CH_COMMISSION);
        p.drive(5'h00, 8'h00);
        @(posedge mclk_in);
        #1;
        chk(16'(owner_out), 16'(CH_NONE), "commission drop");
        p.drive(5'h02, 8'h00);
        @(posedge mclk_in);
        #1;
        chk(16'(ctrl_cmd_out), 16'h0001, "unlocked web cmd");
        p.drive(5'h00, 8'h00);
        $display("test commissioning done");
        tq(4'h1, 8'h11, IO_SCAN_UNIT_ID, 1'h1, 1'h0, 2'h1, CH_IO_SCAN);
        chk(16'(tcp_ack_out), 16'h0001, "ack");
        tq(4'h2, 8'h11, IO_SCAN_UNIT_ID, 1'h1, 1'h0, 2'h1, CH_IO_SCAN);
        chk(16'(tcp_ack_out), 16'h0001, "merged ack");
        tq(4'h5, 8'h22, IO_SCAN_UNIT_ID, 1'h1, 1'h0, 2'h2, CH_IO_SCAN);
        tq(4'h3, 8'h33, 8'h01, 1'h1, 1'h0, 2'h0, CH_IO_SCAN);
        p.drive(5'h01, 8'h00);
        tq(4'h1, 8'h11, IO_SCAN_UNIT_ID, 1'h0, 1'h1, 2'h0, CH_IO_SCAN);
        p.drive(5'h00, 8'h00);
        tq(4'h1, 8'h11, IO_SCAN_UNIT_ID, 1'h0, 1'h1, 2'h0, CH_NONE);
        $display("test io scanning done");
        tq(4'h3, 8'h33, 8'h01, 1'h1, 1'h0, 2'h1, CH_FIELDBUS);
        tq(4'h4, 8'h44, 8'h01, 1'h1, 1'h0, 2'h0, CH_FIELDBUS);
        chk(16'(owner_conn_out), 16'h0003, "owner conn");
        wr(LOCK_REG_OFFSET, LOCK_VAL_LOCK, 1'h0);
        foreach (pv[i]) begin
            p.drive(5'h0E, pv[i]);
            @(posedge mclk_in);
            #1;
            chk(16'({halt_out, fault_reset_out, enable_out, limits_out, ref_out, safe_torque_off_out}),
                16'({pv[i][7:5], pv[i][4] | pv[i][3], pv[i][2:0]}), "pins");
            chk(16'(ctrl_cmd_out), 16'h0000, "locked-out local cmd");
        end
        tq(4'h3, 8'h33, 8'h01, 1'h0, 1'h1, 2'h0, CH_NONE);
        $display("test fieldbus done");
        tq(4'h6, 8'h66, IO_SCAN_UNIT_ID, 1'h1, 1'h0, 2'h1, CH_IO_SCAN);
        rst;
        $display("test second reset done");
        results;
    end
endmodule
